//--- pm_cap_pkg.sv
// constants, settings and carrier types of the power management capability
`default_nettype none
package pm_cap_pkg;

  // ***********************************************************
  // placement and offsets
  // ***********************************************************
  localparam int CFG_DW_ADDR_W = 10;
  localparam logic [11:0] PM_BASE_BYTE = 12'h040;
  localparam logic [11:0] PM_CAP_OFS = 12'h000;
  localparam logic [11:0] PM_CSR_OFS = 12'h004;

  // ***********************************************************
  // capabilities word fields
  // ***********************************************************
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_NEXT_LSB = 8;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_BUS_CLK_BIT = 19;
  localparam int CAP_RSVD_BIT = 20;
  localparam int CAP_DSI_BIT = 21;
  localparam int CAP_AUX_LSB = 22;
  localparam int CAP_D1_BIT = 25;
  localparam int CAP_D2_BIT = 26;
  localparam int CAP_WAKE_LSB = 27;

  // ***********************************************************
  // control/status word fields
  // ***********************************************************
  localparam int CSR_STATE_LSB = 0;
  localparam int CSR_NSR_BIT = 3;
  localparam int CSR_WAKE_EN_BIT = 8;
  localparam int CSR_SEL_LSB = 9;
  localparam int CSR_SCALE_LSB = 13;
  localparam int CSR_WAKE_ST_BIT = 15;
  localparam int CSR_B2B3_BIT = 22;
  localparam int CSR_BPCC_BIT = 23;
  localparam int CSR_DATA_LSB = 24;

  // ***********************************************************
  // fixed values and reset values
  // ***********************************************************
  localparam logic [1:0] STATE_D0 = 2'h0;
  localparam logic [1:0] STATE_D1 = 2'h1;
  localparam logic [1:0] STATE_D2 = 2'h2;
  localparam logic [1:0] STATE_D3 = 2'h3;
  localparam logic [1:0] STATE_RST = 2'h0;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] SEL_LAST = 4'h7;
  localparam logic BUS_CLK_FIXED = 1'b0;
  localparam logic RSVD20_FIXED = 1'b0;
  localparam logic NSR_FIXED = 1'b1;

  // ***********************************************************
  // carrier types
  // ***********************************************************
  typedef logic [7:0][7:0] power_bank_t;
  typedef logic [7:0][1:0] scale_bank_t;

  typedef struct packed {
    logic pm_struct_present;
    logic [7:0] pm_capability_identifier;
    logic [7:0] pm_next_item_pointer;
    logic [2:0] pm_spec_version;
    logic wake_needs_bus_clock;
    logic pm_reserved_bit20;
    logic device_specific_init_flag;
    logic [2:0] aux_current_request;
    logic state_d1_supported;
    logic state_d2_supported;
    logic [4:0] wake_event_state_support;
    logic bus_b2_b3_flag;
    logic bus_power_clock_ctrl_enable;
    logic no_soft_reset_flag;
    power_bank_t power_value;
    scale_bank_t power_scale;
  } pm_attr_s;

  localparam pm_attr_s PM_ATTR_DEFAULT = '{
    pm_struct_present: 1'b1,
    pm_capability_identifier: 8'h01,
    pm_spec_version: 3'h3,
    no_soft_reset_flag: 1'b1,
    default: '0
  };

  typedef struct packed {
    logic valid;
    logic write;
    logic [CFG_DW_ADDR_W-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [31:0] rdata;
  } cfg_rsp_s;

  typedef struct packed {
    logic [1:0] power_state;
    logic wake_enable;
    logic [3:0] data_select;
    logic wake_status;
    cfg_rsp_s link_rsp;
    cfg_rsp_s mgmt_rsp;
  } pm_state_s;

  typedef struct packed {
    logic [7:0] data;
    logic [1:0] scale;
  } pm_table_s;

endpackage : pm_cap_pkg
`default_nettype wire

//--- pm_cap_properties.sv
// port assertions of the power management capability block
`timescale 1ns/1ps
`default_nettype none
module pm_cap_properties
  import pm_cap_pkg::*;
#(
  parameter pm_attr_s attrs = PM_ATTR_DEFAULT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire cfg_req_s link_req,
  input wire cfg_req_s mgmt_req,
  input wire logic mgmt_ready,
  input wire cfg_rsp_s link_rsp,
  input wire cfg_rsp_s mgmt_rsp
);
  // ****************
  // link reads of the two words
  // ****************
  logic cap_rd;
  logic csr_rd;
  assign cap_rd = link_req.valid && !link_req.write && link_req.addr == 10'h010 && attrs.pm_struct_present;
  assign csr_rd = link_req.valid && !link_req.write && link_req.addr == 10'h011 && attrs.pm_struct_present;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_link_answer: assert property (link_req.valid |=> link_rsp.valid)
    else $error("link request unanswered");
  a_answer_once: assert property (!link_req.valid |=> !link_rsp.valid)
    else $error("answer without request");
  a_mgmt_answer: assert property (mgmt_req.valid && mgmt_ready |=> mgmt_rsp.valid)
    else $error("management request unanswered");
  a_absent_miss: assert property (link_req.valid && !attrs.pm_struct_present |=> !link_rsp.hit && link_rsp.rdata == 32'h0)
    else $error("absent structure answered");
  a_cap_ident: assert property (cap_rd |=> link_rsp.hit && link_rsp.rdata[7:0] == attrs.pm_capability_identifier)
    else $error("identifier wrong");
  a_next_pointer: assert property (cap_rd |=> link_rsp.rdata[15:8] == attrs.pm_next_item_pointer)
    else $error("next pointer wrong");
  a_spec_version: assert property (cap_rd |=> link_rsp.rdata[18:16] == 3'h3)
    else $error("version wrong");
  a_fixed_zero: assert property (cap_rd |=> link_rsp.rdata[20:19] == 2'h0)
    else $error("bits 20:19 not zero");
  a_cap_flags: assert property (cap_rd |=> link_rsp.rdata[31:21] == {attrs.wake_event_state_support,
    attrs.state_d2_supported, attrs.state_d1_supported, attrs.aux_current_request,
    attrs.device_specific_init_flag})
    else $error("capability flags wrong");
  a_csr_flags: assert property (csr_rd |=> link_rsp.rdata[3] && link_rsp.rdata[23:22] ==
    {attrs.bus_power_clock_ctrl_enable, attrs.bus_b2_b3_flag})
    else $error("status flags wrong");
endmodule : pm_cap_properties
bind pm_capability_config_space pm_cap_properties #(.attrs(attrs)) i_pm_cap_properties (.mclk(mclk), .rst(rst),
  .link_req(link_req), .mgmt_req(mgmt_req), .mgmt_ready(mgmt_ready), .link_rsp(link_rsp), .mgmt_rsp(mgmt_rsp));
`default_nettype wire

//--- pm_capability_config_space.sv
// power management capability structure of the configuration space
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - structure sits at byte 40h, accesses relative
// - absent structure answers link and management with a miss, data 0
// - identifier in capabilities bits 7:0
// - next pointer reported, 00h when last
// - spec version in bits 18:16, from the pm_spec_version setting, 3 by default
// - bus clock for wake bit 19 reads 0
// - reserved bit 20 reads 0
// - device specific init flag in bit 21
// - aux current request in bits 24:22
// - D1 support bit 25, D2 bit 26
// - wake support D3cold..D0 in bits 31:27
// - B2/B3 bit 22, bus power/clock bit 23
// - no soft reset bit 3 reads 1
// - select 0..3 returns consumed power value
// - select 4..7 returns dissipated power value
// - each value returns its two-bit scale
module pm_capability_config_space
  import pm_cap_pkg::*;
#(
  parameter pm_attr_s attrs = PM_ATTR_DEFAULT
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire cfg_req_s link_req,
  input wire cfg_req_s mgmt_req,
  output logic mgmt_ready,
  output cfg_rsp_s link_rsp,
  output cfg_rsp_s mgmt_rsp,
  input wire logic wake_event,
  output logic [1:0] power_state,
  output logic wake_enable,
  output logic wake_status
);

  // ***********************************************************
  // functions
  // ***********************************************************

  // byte address of a dword request
  function automatic logic [11:0] byte_addr(input cfg_req_s r);
    byte_addr = {r.addr, 2'b00};
  endfunction : byte_addr

  // true when the request lands on one word of the structure
  function automatic logic hits_word(input cfg_req_s r, input logic [11:0] ofs);
    logic [11:0] target;
    target = PM_BASE_BYTE + ofs;
    hits_word = attrs.pm_struct_present && (byte_addr(r) == target);
  endfunction : hits_word

  // a power state write is kept only if that state is supported
  function automatic logic state_allowed(input logic [1:0] s);
    case (s)
      STATE_D0: state_allowed = 1'b1;
      STATE_D1: state_allowed = attrs.state_d1_supported;
      STATE_D2: state_allowed = attrs.state_d2_supported;
      STATE_D3: state_allowed = 1'b1;
      default: state_allowed = 1'b0;
    endcase
  endfunction : state_allowed

  // ***********************************************************
  // state
  // ***********************************************************
  pm_state_s st;
  pm_state_s next_st;
  logic [31:0] cap_word;
  logic [31:0] csr_word;
  logic [7:0] table_data;
  logic [1:0] table_scale;
  logic [3:0] table_sel;
  cfg_req_s req;
  logic from_link;
  logic hit_cap;
  logic hit_csr;
  logic [1:0] wr_state;
  logic wake_clear;

  // ***********************************************************
  // capabilities word, from settings except fixed bits 20:19
  // ***********************************************************
  always_comb
  begin
    cap_word = '0;
    cap_word[CAP_ID_LSB +: 8] = attrs.pm_capability_identifier;
    cap_word[CAP_NEXT_LSB +: 8] = attrs.pm_next_item_pointer;
    cap_word[CAP_VER_LSB +: 3] = attrs.pm_spec_version;
    // forced, since the only legal setting is zero
    cap_word[CAP_BUS_CLK_BIT] = BUS_CLK_FIXED;
    cap_word[CAP_RSVD_BIT] = RSVD20_FIXED;
    cap_word[CAP_DSI_BIT] = attrs.device_specific_init_flag;
    cap_word[CAP_AUX_LSB +: 3] = attrs.aux_current_request;
    cap_word[CAP_D1_BIT] = attrs.state_d1_supported;
    cap_word[CAP_D2_BIT] = attrs.state_d2_supported;
    cap_word[CAP_WAKE_LSB +: 5] = attrs.wake_event_state_support;
  end

  // ***********************************************************
  // control/status word
  // ***********************************************************
  always_comb
  begin
    csr_word = '0;
    csr_word[CSR_STATE_LSB +: 2] = st.power_state;
    csr_word[CSR_NSR_BIT] = NSR_FIXED;
    csr_word[CSR_WAKE_EN_BIT] = st.wake_enable;
    csr_word[CSR_SEL_LSB +: 4] = st.data_select;
    csr_word[CSR_SCALE_LSB +: 2] = table_scale;
    csr_word[CSR_WAKE_ST_BIT] = st.wake_status;
    csr_word[CSR_B2B3_BIT] = attrs.bus_b2_b3_flag;
    csr_word[CSR_BPCC_BIT] = attrs.bus_power_clock_ctrl_enable;
    csr_word[CSR_DATA_LSB +: 8] = table_data;
  end

  // ***********************************************************
  // request selection
  // ***********************************************************
  // link wins a tie; the management port waits, never the link
  always_comb
  begin
    from_link = link_req.valid;
    req = from_link ? link_req : mgmt_req;
    hit_cap = req.valid && hits_word(req, PM_CAP_OFS);
    hit_csr = req.valid && hits_word(req, PM_CSR_OFS);
  end

  assign mgmt_ready = !link_req.valid;

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb
  begin
    cfg_rsp_s rsp;
    rsp = '0;
    next_st = st;
    wr_state = req.wdata[CSR_STATE_LSB +: 2];
    wake_clear = 1'b0;
    next_st.link_rsp = '0;
    next_st.mgmt_rsp = '0;

    // writes to the capabilities word fall through untouched
    if (req.valid && req.write && hit_csr)
    begin
      if (req.be[0] && state_allowed(wr_state))
      begin
        next_st.power_state = wr_state;
      end
      if (req.be[1])
      begin
        next_st.wake_enable = req.wdata[CSR_WAKE_EN_BIT];
        next_st.data_select = req.wdata[CSR_SEL_LSB +: 4];
        wake_clear = req.wdata[CSR_WAKE_ST_BIT];
      end
    end

    // a wake event in the clearing cycle keeps the flag set
    if (wake_event)
    begin
      next_st.wake_status = 1'b1;
    end
    else if (wake_clear)
    begin
      next_st.wake_status = 1'b0;
    end

    rsp.valid = req.valid;
    rsp.hit = hit_cap || hit_csr;
    if (req.valid && !req.write)
    begin
      if (hit_cap)
      begin
        rsp.rdata = cap_word;
      end
      else if (hit_csr)
      begin
        rsp.rdata = csr_word;
      end
    end

    if (from_link)
    begin
      next_st.link_rsp = rsp;
    end
    else
    begin
      next_st.mgmt_rsp = rsp;
    end
  end

  // table follows the select in the same edge, so a read right
  // after a select write already sees the new value
  assign table_sel = next_st.data_select;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.power_state <= STATE_RST;
      st.data_select <= SEL_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ***********************************************************
  // power data table
  // ***********************************************************
  pm_power_table u_table (
    .mclk(mclk),
    .rst(rst),
    .sel(table_sel),
    .values(attrs.power_value),
    .scales(attrs.power_scale),
    .data(table_data),
    .scale(table_scale)
  );

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign link_rsp = st.link_rsp;
  assign mgmt_rsp = st.mgmt_rsp;
  assign power_state = st.power_state;
  assign wake_enable = st.wake_enable;
  assign wake_status = st.wake_status;

endmodule : pm_capability_config_space
`default_nettype wire

//--- pm_capability_config_space_tb.sv
// self-checking bench of the power management capability block
`timescale 1ns/1ps
`default_nettype none
module pm_capability_config_space_tb import pm_cap_pkg::*;;
  localparam pm_attr_s attrs_on = '{pm_struct_present: 1'h1, pm_capability_identifier: 8'h01,
    pm_next_item_pointer: 8'h48, pm_spec_version: 3'h3, device_specific_init_flag: 1'h1,
    aux_current_request: 3'h5, state_d1_supported: 1'h1, wake_event_state_support: 5'h19,
    bus_b2_b3_flag: 1'h1, no_soft_reset_flag: 1'h1, power_value: 64'h8877665544332211,
    power_scale: 16'hE4E4, default: '0};
  localparam pm_attr_s attrs_off = '{pm_struct_present: 1'h0, pm_capability_identifier: 8'h01,
    pm_spec_version: 3'h3, no_soft_reset_flag: 1'h1, default: '0};
  localparam logic [31:0] cap_exp = {5'h19, 1'h0, 1'h1, 3'h5, 1'h1, 2'h0, 3'h3, 8'h48, 8'h01};
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic wake_event = 1'h0;
  cfg_req_s link_req;
  cfg_req_s mgmt_req;
  logic mgmt_ready;
  cfg_rsp_s link_rsp;
  cfg_rsp_s mgmt_rsp;
  cfg_rsp_s off_rsp;
  cfg_rsp_s off_mrsp;
  cfg_rsp_s rsp;
  cfg_rsp_s mrsp;
  logic [1:0] power_state;
  logic wake_enable;
  logic wake_status;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  pm_capability_config_space #(.attrs(attrs_on)) i_pm_capability_config_space (.mclk(mclk), .rst(rst),
    .link_req(link_req), .mgmt_req(mgmt_req), .mgmt_ready(mgmt_ready), .link_rsp(link_rsp),
    .mgmt_rsp(mgmt_rsp), .wake_event(wake_event), .power_state(power_state), .wake_enable(wake_enable),
    .wake_status(wake_status));
  pm_capability_config_space #(.attrs(attrs_off)) i_pm_capability_config_space_off (.mclk(mclk), .rst(rst),
    .link_req(link_req), .mgmt_req(mgmt_req), .mgmt_ready(), .link_rsp(off_rsp),
    .mgmt_rsp(off_mrsp), .wake_event(wake_event), .power_state(), .wake_enable(), .wake_status());
  pm_host_model i_pm_host_model (.mclk(mclk), .link_req(link_req), .mgmt_req(mgmt_req),
    .mgmt_ready(mgmt_ready), .link_rsp(link_rsp), .mgmt_rsp(mgmt_rsp));
  always #4 mclk = ~mclk;
  // run needs about 110 cycles, ceiling leaves wide margin
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      failures++;
      results();
    end
  end
  // ****************
  // checks and tests
  // ****************
  task check(input logic [33:0] got, input logic [33:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      failures++;
    end
  endtask : check
  task test_cap_word;
    i_pm_host_model.access(1'h0, 1'h0, 10'h010, 4'h0, 32'h0, rsp);
    check(rsp, {2'h3, cap_exp}, "link cap");
    check(off_rsp, {2'h2, 32'h0}, "absent link");
    i_pm_host_model.access(1'h1, 1'h0, 10'h010, 4'h0, 32'h0, rsp);
    check(rsp, {2'h3, cap_exp}, "mgmt cap");
    check(off_mrsp, {2'h2, 32'h0}, "absent mgmt");
    i_pm_host_model.access(1'h0, 1'h0, 10'h000, 4'h0, 32'h0, rsp);
    check(rsp, {2'h2, 32'h0}, "below base");
    $display("test_cap_word done");
  endtask : test_cap_word
  task test_cap_write;
    i_pm_host_model.access(1'h0, 1'h1, 10'h010, 4'hF, 32'hFFFFFFFF, rsp);
    check(rsp, {2'h3, 32'h0}, "cap write");
    i_pm_host_model.access(1'h1, 1'h1, 10'h010, 4'hF, 32'h0, rsp);
    i_pm_host_model.access(1'h0, 1'h0, 10'h010, 4'h0, 32'h0, rsp);
    check(rsp, {2'h3, cap_exp}, "cap after writes");
    $display("test_cap_write done");
  endtask : test_cap_write
  task test_power_data;
    logic [31:0] e;
    for (int s = 0; s < 16; s++)
    begin
      i_pm_host_model.access(s[0], 1'h1, 10'h011, 4'h2, 32'(s) << 9, rsp);
      i_pm_host_model.access(~s[0], 1'h0, 10'h011, 4'h0, 32'h0, rsp);
      e = {s < 8 ? 8'h11 * 8'(s + 1) : 8'h00, 8'h40, 1'h0, s < 8 ? 2'(s) : 2'h0, 4'(s), 9'h008};
      check(rsp, {2'h3, e}, "status word");
    end
    $display("test_power_data done");
  endtask : test_power_data
  // d1 supported, d2 not; set must beat a same-cycle clear
  task test_csr_fields;
    i_pm_host_model.access(1'h0, 1'h1, 10'h011, 4'h1, 32'h00000001, rsp);
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'h1}, "state d1");
    i_pm_host_model.access(1'h1, 1'h1, 10'h011, 4'h1, 32'h00000002, rsp);
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'h1}, "state d2 dropped");
    i_pm_host_model.access(1'h0, 1'h1, 10'h011, 4'h2, 32'h00000103, rsp);
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'h5}, "wake enable");
    @(negedge mclk);
    wake_event = 1'h1;
    @(negedge mclk);
    wake_event = 1'h0;
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'hD}, "wake set");
    @(negedge mclk);
    wake_event = 1'h1;
    i_pm_host_model.access(1'h0, 1'h1, 10'h011, 4'h2, 32'h00008100, rsp);
    wake_event = 1'h0;
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'hD}, "set beats clear");
    i_pm_host_model.access(1'h1, 1'h1, 10'h011, 4'h2, 32'h00008100, rsp);
    check({30'h0, wake_status, wake_enable, power_state}, {30'h0, 4'h5}, "wake cleared");
    fork
      i_pm_host_model.access(1'h0, 1'h0, 10'h011, 4'h0, 32'h0, rsp);
      i_pm_host_model.access(1'h1, 1'h0, 10'h010, 4'h0, 32'h0, mrsp);
    join
    check(rsp, {2'h3, 8'h11, 8'h40, 1'h0, 2'h0, 4'h0, 9'h109}, "link beats mgmt");
    check(mrsp, {2'h3, cap_exp}, "mgmt waits");
    @(negedge mclk);
    rst = 1'h1;
    repeat (2) @(negedge mclk);
    rst = 1'h0;
    check({30'h0, wake_status, wake_enable, power_state}, 34'h0, "reset outputs");
    i_pm_host_model.access(1'h0, 1'h0, 10'h011, 4'h0, 32'h0, rsp);
    check(rsp, {2'h3, 8'h11, 8'h40, 1'h0, 2'h0, 4'h0, 9'h008}, "status after reset");
    $display("test_csr_fields done");
  endtask : test_csr_fields
  task results;
    $display("checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    test_cap_word();
    test_cap_write();
    test_power_data();
    test_csr_fields();
    results();
  end
endmodule : pm_capability_config_space_tb
`default_nettype wire

//--- pm_host_model.sv
// host issuing configuration accesses over link or management port
`timescale 1ns/1ps
`default_nettype none
module pm_host_model
  import pm_cap_pkg::*;
(
  input wire logic mclk,
  output cfg_req_s link_req,
  output cfg_req_s mgmt_req,
  input wire logic mgmt_ready,
  input wire cfg_rsp_s link_rsp,
  input wire cfg_rsp_s mgmt_rsp
);
  initial
  begin
    link_req = '0;
    mgmt_req = '0;
  end
  // ****************
  // one dword access, held until taken
  // ****************
  task automatic access(input logic mg, input logic wr, input logic [9:0] a, input logic [3:0] b,
    input logic [31:0] d, output cfg_rsp_s r);
    cfg_req_s q;
    int n;
    q = '{valid: 1'h1, write: wr, addr: a, be: b, wdata: d};
    n = 0;
    @(negedge mclk);
    if (mg) mgmt_req = q;
    else link_req = q;
    @(posedge mclk);
    while (mg && !mgmt_ready && n < 50)
    begin
      n++;
      @(posedge mclk);
    end
    @(negedge mclk);
    r = mg ? mgmt_rsp : link_rsp;
    // released lines show the inverse, not a stale copy
    q = '{valid: 1'h0, write: ~wr, addr: ~a, be: ~b, wdata: ~d};
    if (mg) mgmt_req = q;
    else link_req = q;
  endtask : access
endmodule : pm_host_model
`default_nettype wire

//--- pm_power_table.sv
// power data table with registered read port
`timescale 1ns/1ps
`default_nettype none
module pm_power_table
  import pm_cap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] sel,
  input wire power_bank_t values,
  input wire scale_bank_t scales,
  output logic [7:0] data,
  output logic [1:0] scale
);

  pm_table_s st;
  pm_table_s next_st;

  // ***********************************************************
  // lookup
  // ***********************************************************
  always_comb
  begin
    next_st = '0;
    // undefined selections read as zero
    if (sel <= SEL_LAST)
    begin
      next_st.data = values[sel[2:0]];
      next_st.scale = scales[sel[2:0]];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign data = st.data;
  assign scale = st.scale;

endmodule : pm_power_table
`default_nettype wire
